// ---- logic/cmt_pkg.sv ----
// constants and carrier types for the single-mailbox transmit control block
// assumes one clock (hclk) and a CAN frame engine on the same clock
package cmt_pkg;

  // register byte offsets
  localparam logic [7:0] CMT_OFS_CTRL = 8'h00;
  localparam logic [7:0] CMT_OFS_TRIG = 8'h04;
  localparam logic [7:0] CMT_OFS_PEND = 8'h08;
  localparam logic [7:0] CMT_OFS_STAT = 8'h0C;
  localparam logic [7:0] CMT_OFS_MASK = 8'h10;
  localparam logic [7:0] CMT_OFS_CNT = 8'h14;
  localparam logic [7:0] CMT_OFS_DLO = 8'h18;
  localparam logic [7:0] CMT_OFS_DHI = 8'h1C;

  // control word fields
  localparam int CMT_B_TTE = 14;
  localparam int CMT_B_ATX = 12;
  localparam int CMT_B_NORETRY = 11;
  localparam int CMT_B_ROLE_HI = 10;
  localparam int CMT_B_ROLE_LO = 8;
  localparam int CMT_B_PTE = 7;
  localparam int CMT_B_TCT = 6;
  localparam int CMT_B_FAULT = 5;
  localparam int CMT_B_DLC_HI = 3;
  localparam logic [15:0] CMT_CTRL_RST = 16'h0000;
  localparam logic [15:0] CMT_CTRL_WMASK = 16'h5FDF;

  // pending register bits
  localparam int CMT_B_PENDING = 0;
  localparam int CMT_B_CANCEL = 1;

  // status / mask bits
  localparam int CMT_NUM_EV = 4;
  localparam int CMT_EV_SENT = 0;
  localparam int CMT_EV_REMOTE = 1;
  localparam int CMT_EV_CANCEL = 2;
  localparam int CMT_EV_FAULT = 3;

  // role codes
  localparam logic [2:0] CMT_ROLE_TX = 3'h0;
  localparam logic [2:0] CMT_ROLE_TX_REPLY = 3'h1;

  localparam logic [3:0] CMT_DLC_EMBED_MIN = 4'h8;
  localparam int CMT_SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    CMT_ST_IDLE = 3'b001,
    CMT_ST_READY = 3'b010,
    CMT_ST_BUSY = 3'b100
  } cmt_state_e;

  // toward the frame engine
  typedef struct packed {
    logic req;
    logic [3:0] dlc;
    logic [63:0] data;
  } cmt_tx_s;

  // events from the frame engine, one-cycle pulses except rx fields
  typedef struct packed {
    logic tx_start;
    logic tx_done;
    logic tx_fail;
    logic rx_end;
    logic rx_remote;
    logic [3:0] rx_dlc;
  } cmt_ev_s;

endpackage

// ---- logic/cmt_sync.sv ----
// two-stage synchroniser for a level from outside the clock domain
// assumes the input is a slow level; glitches shorter than a cycle may be lost
`timescale 1ns/10ps
module cmt_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ---- logic/cmt_mailbox_ctrl.sv ----
// one CAN mailbox: control word, timed/periodic send, auto reply, no-retry
// assumes an AHB-Lite master on hclk and a frame engine on the same clock
`timescale 1ns/10ps
module cmt_mailbox_ctrl #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // frame engine
  input wire cmt_pkg::cmt_ev_s eng_ev,
  output cmt_pkg::cmt_tx_s eng_tx,
  // transceiver pin and interrupt
  input wire logic transceiver_fault_in,
  output logic irq
);
  import cmt_pkg::*;

  // register state
  logic [15:0] mailbox_control_word;
  logic [CNT_W-1:0] send_trigger_time;
  logic [CNT_W-1:0] cycle_time_counter;
  logic send_pending;
  logic send_cancel_request;
  logic [CMT_NUM_EV-1:0] irq_status;
  logic [CMT_NUM_EV-1:0] irq_mask;
  logic [31:0] payload_lo;
  logic [31:0] payload_hi;
  logic reply_active;
  logic [3:0] reply_dlc;
  cmt_state_e state;
  cmt_state_e next_state;

  // bus data phase
  logic dp_write;
  logic [7:0] dp_addr;

  logic fault_sync;
  cmt_sync #(.WIDTH(1)) u_fault_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(transceiver_fault_in),
    .sync_out(fault_sync)
  );

  // control fields
  wire time_trigger_enable = mailbox_control_word[CMT_B_TTE];
  wire auto_remote_reply = mailbox_control_word[CMT_B_ATX];
  wire no_retry_enable = mailbox_control_word[CMT_B_NORETRY];
  wire [2:0] mailbox_role_config = mailbox_control_word[CMT_B_ROLE_HI:CMT_B_ROLE_LO];
  wire periodic_send_enable = mailbox_control_word[CMT_B_PTE];
  wire counter_embed_enable = mailbox_control_word[CMT_B_TCT];
  wire [3:0] stored_dlc = mailbox_control_word[CMT_B_DLC_HI:0];

  // roles 000 and 001 transmit; others never raise a request
  wire role_is_tx = (mailbox_role_config == CMT_ROLE_TX) ||
                    (mailbox_role_config == CMT_ROLE_TX_REPLY);
  wire role_reply = (mailbox_role_config == CMT_ROLE_TX_REPLY);

  // bus decode
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_ctrl = dp_write && (dp_addr == CMT_OFS_CTRL);
  wire wr_trig = dp_write && (dp_addr == CMT_OFS_TRIG);
  wire wr_pend = dp_write && (dp_addr == CMT_OFS_PEND);
  wire wr_stat = dp_write && (dp_addr == CMT_OFS_STAT);
  wire wr_mask = dp_write && (dp_addr == CMT_OFS_MASK);
  wire wr_dlo = dp_write && (dp_addr == CMT_OFS_DLO);
  wire wr_dhi = dp_write && (dp_addr == CMT_OFS_DHI);
  wire sw_set_pending = wr_pend && hwdata[CMT_B_PENDING];
  wire sw_cancel = wr_pend && hwdata[CMT_B_CANCEL];

  // remote frame answered only in reply role with auto reply on
  wire remote_hit = eng_ev.rx_end && eng_ev.rx_remote && auto_remote_reply &&
                    role_reply;
  wire trig_hit = (cycle_time_counter == send_trigger_time);
  wire launch_ok = !time_trigger_enable || trig_hit;
  wire periodic = periodic_send_enable && time_trigger_enable;
  wire frame_end = eng_ev.tx_done || eng_ev.tx_fail || eng_ev.rx_end;
  wire cancel_now = send_cancel_request || sw_cancel;

  // length used on the wire
  wire [3:0] next_dlc = reply_active ? reply_dlc : stored_dlc;
  wire embed = counter_embed_enable && role_is_tx &&
               (stored_dlc >= CMT_DLC_EMBED_MIN);

  // send state machine
  always_comb begin
    next_state = state;
    unique case (state)
      CMT_ST_IDLE: begin
        if (send_pending && !cancel_now && role_is_tx && launch_ok) begin
          next_state = CMT_ST_READY;
        end
      end
      CMT_ST_READY: begin
        if (eng_ev.tx_start) begin
          next_state = CMT_ST_BUSY;
        end else if (cancel_now || !send_pending || !role_is_tx) begin
          next_state = CMT_ST_IDLE;
        end
      end
      CMT_ST_BUSY: begin
        if (eng_ev.tx_done || eng_ev.tx_fail) begin
          next_state = CMT_ST_IDLE;
        end
      end
    endcase
  end

  // pending: cleared on success unless periodic, on cancel, on single failed try
  wire done_clear = eng_ev.tx_done && !periodic;
  wire fail_clear = eng_ev.tx_fail && cancel_now;
  wire idle_cancel = cancel_now && (state != CMT_ST_BUSY);
  wire clear_pending = (state == CMT_ST_BUSY) ? (done_clear || fail_clear ||
                       (eng_ev.tx_done && cancel_now)) : idle_cancel;
  wire next_pending = (send_pending && !clear_pending) || sw_set_pending ||
                      remote_hit;

  // cancel request stays until the attempt in flight resolves
  wire start_single = eng_ev.tx_start && no_retry_enable;
  wire cancel_done = (state == CMT_ST_BUSY) ? (eng_ev.tx_done || eng_ev.tx_fail) :
                     (state == CMT_ST_IDLE);
  wire next_cancel = (send_cancel_request && !cancel_done) || sw_cancel || start_single;
  wire cancelled_ev = send_pending && clear_pending && cancel_now && !eng_ev.tx_done;

  wire [CMT_NUM_EV-1:0] ev_set;
  assign ev_set[CMT_EV_SENT] = (state == CMT_ST_BUSY) && eng_ev.tx_done;
  assign ev_set[CMT_EV_REMOTE] = remote_hit;
  assign ev_set[CMT_EV_CANCEL] = cancelled_ev;
  assign ev_set[CMT_EV_FAULT] = frame_end && fault_sync;
  wire [CMT_NUM_EV-1:0] ev_clr = wr_stat ? hwdata[CMT_NUM_EV-1:0] : '0;
  wire [CMT_NUM_EV-1:0] next_status = (irq_status & ~ev_clr) | ev_set;

  // control word: software write, then the fault copy on frame end
  logic [15:0] next_ctrl;
  always_comb begin
    next_ctrl = mailbox_control_word;
    if (wr_ctrl) begin
      next_ctrl = (hwdata[15:0] & CMT_CTRL_WMASK) |
                  (mailbox_control_word & ~CMT_CTRL_WMASK);
    end
    if (frame_end) begin
      next_ctrl[CMT_B_FAULT] = fault_sync;
    end
  end

  // read mux, sampled in the address phase
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr)
      CMT_OFS_CTRL: rd_mux = {16'h0000, mailbox_control_word};
      CMT_OFS_TRIG: rd_mux = 32'(send_trigger_time);
      CMT_OFS_PEND: rd_mux = {30'h0000_0000, send_cancel_request, send_pending};
      CMT_OFS_STAT: rd_mux = 32'(irq_status);
      CMT_OFS_MASK: rd_mux = 32'(irq_mask);
      CMT_OFS_CNT: rd_mux = 32'(cycle_time_counter);
      CMT_OFS_DLO: rd_mux = payload_lo;
      CMT_OFS_DHI: rd_mux = payload_hi;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // outgoing payload; bytes six and seven take the counter at start of frame
  wire [63:0] stored_payload = {payload_hi, payload_lo};
  logic [63:0] next_tx_data;
  always_comb begin
    next_tx_data = stored_payload;
    if (eng_ev.tx_start && embed) begin
      next_tx_data[63:48] = 16'(cycle_time_counter);
    end else if (state == CMT_ST_BUSY) begin
      next_tx_data = eng_tx.data;
    end
  end

  // bus data phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= addr_phase && hwrite;
      dp_addr <= haddr;
    end
  end

  // read data stands for the data phase only, zero otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // never waits, never errors: every register answers in one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // software-owned configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_trigger_time <= '0;
      irq_mask <= '0;
      payload_lo <= 32'h0000_0000;
      payload_hi <= 32'h0000_0000;
    end else begin
      if (wr_trig) send_trigger_time <= hwdata[CNT_W-1:0];
      if (wr_mask) irq_mask <= hwdata[CMT_NUM_EV-1:0];
      if (wr_dlo) payload_lo <= hwdata;
      if (wr_dhi) payload_hi <= hwdata;
    end
  end

  // free-running cycle counter; one match per wrap gives one periodic send
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_time_counter <= '0;
    end else begin
      cycle_time_counter <= cycle_time_counter + 1'b1;
    end
  end

  // send state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= CMT_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // control word; the fault copy rides in next_ctrl
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mailbox_control_word <= CMT_CTRL_RST;
    end else begin
      mailbox_control_word <= next_ctrl;
    end
  end

  // pending and cancel request; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_pending <= 1'b0;
      send_cancel_request <= 1'b0;
    end else begin
      send_pending <= next_pending;
      send_cancel_request <= next_cancel;
    end
  end

  // sticky status; irq from next_status so it rises with the status bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end

  // reply length is kept until the reply has gone out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reply_active <= 1'b0;
      reply_dlc <= 4'h0;
    end else if (remote_hit) begin
      reply_active <= 1'b1;
      reply_dlc <= eng_ev.rx_dlc;
    end else if (!next_pending) begin
      reply_active <= 1'b0;
    end
  end

  // frame engine side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_tx <= '0;
    end else begin
      eng_tx.req <= (next_state == CMT_ST_READY);
      eng_tx.dlc <= (state == CMT_ST_BUSY) ? eng_tx.dlc : next_dlc;
      eng_tx.data <= next_tx_data;
    end
  end

endmodule

// ---- tb/cmt_mailbox_ctrl_assertions.sv ----
// checker for the mailbox control block, bound to its ports
// assumes a same-clock frame engine and single-word bus writes
`timescale 1ns/10ps
module cmt_mailbox_ctrl_checker import cmt_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // engine, pin, interrupt
  input wire cmt_pkg::cmt_ev_s eng_ev,
  input wire cmt_pkg::cmt_tx_s eng_tx,
  input wire logic transceiver_fault_in,
  input wire logic irq
);
  // wide enough for one counter wrap at the bench width
  localparam int PER_MAX = 1000;
  logic a_wr;
  logic [7:0] a_ad;
  logic [15:0] ctrl;
  logic [15:0] trig;
  logic [CNT_W-1:0] cnt;
  logic sending;
  wire role_bad = ctrl[10:9] != 2'h0;
  wire fin = eng_ev.tx_done | eng_ev.tx_fail;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // shadow of control and trigger words, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr <= 1'b0;
      a_ad <= 8'h00;
      ctrl <= 16'h0000;
      trig <= 16'h0000;
    end else begin
      a_wr <= hsel & hready & htrans[1] & hwrite;
      a_ad <= haddr;
      if (a_wr && a_ad == CMT_OFS_CTRL) ctrl <= hwdata[15:0];
      if (a_wr && a_ad == CMT_OFS_TRIG) trig <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      sending <= 1'b0;
    end else begin
      cnt <= cnt + 1'b1;
      sending <= eng_ev.tx_start | (sending & ~fin);
    end
  end

  sequence s_rerequest;
    ##[1:3] eng_tx.req;
  endsequence

  AST_REQ_DROP: assert property (eng_ev.tx_start |=> !eng_tx.req)
    else $error("request held after start");
  AST_FROZEN: assert property (sending |-> $stable(eng_tx.dlc) && $stable(eng_tx.data[47:0]))
    else $error("frame fields changed in a send");
  AST_EMBED: assert property (eng_ev.tx_start && ctrl[6] && ctrl[10:8] == CMT_ROLE_TX && eng_tx.dlc[3]
    |=> eng_tx.data[63:48] == 16'($past(cnt)))
    else $error("counter not embedded");
  AST_ROLE: assert property (role_bad && $past(role_bad) |-> !eng_tx.req)
    else $error("request from a non-transmit role");
  AST_NORETRY: assert property (eng_ev.tx_fail && ctrl[11] |=> !eng_tx.req [*8])
    else $error("retry with no-retry set");
  AST_RETRY: assert property (eng_ev.tx_fail && !ctrl[11] && !ctrl[14] |-> s_rerequest)
    else $error("no retry after failure");
  AST_TRIG: assert property ($rose(eng_tx.req) && ctrl[14] |-> $past(cnt) == trig[CNT_W-1:0])
    else $error("timed send off trigger time");
  AST_PERIODIC: assert property (eng_ev.tx_done && ctrl[7] && ctrl[14]
    |-> ##[1:PER_MAX] $rose(eng_tx.req))
    else $error("periodic send not repeated");
endmodule

bind cmt_mailbox_ctrl cmt_mailbox_ctrl_checker #(.CNT_W(CNT_W)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .eng_ev(eng_ev), .eng_tx(eng_tx),
  .transceiver_fault_in(transceiver_fault_in), .irq(irq)
);

// ---- tb/cmt_engine_model.sv ----
// frame engine stand-in: takes a send request, reports start and end
// assumes the mailbox on the same clock; bench picks delay and outcome
`timescale 1ns/10ps
module cmt_engine_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // mailbox side
  input wire cmt_pkg::cmt_tx_s eng_tx,
  output cmt_pkg::cmt_ev_s eng_ev,
  // bench controls
  input wire logic fail_en,
  input wire logic [3:0] delay,
  input wire logic rx_go,
  input wire logic [3:0] rx_len
);
  import cmt_pkg::*;
  logic [1:0] st;
  logic [3:0] w;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_ev <= '0;
      st <= 2'h0;
      w <= 4'h0;
    end else begin
      eng_ev.tx_start <= 1'b0;
      eng_ev.tx_done <= 1'b0;
      eng_ev.tx_fail <= 1'b0;
      eng_ev.rx_end <= rx_go;
      eng_ev.rx_remote <= rx_go;
      // length only valid with the frame end, garbage otherwise
      eng_ev.rx_dlc <= rx_go ? rx_len : ~rx_len;
      case (st)
        2'h0: begin
          w <= delay;
          if (eng_tx.req) st <= 2'h1;
        end
        2'h1: begin
          w <= w - 4'h1;
          if (w == 4'h0) begin
            st <= {eng_tx.req, 1'b0};
            eng_ev.tx_start <= eng_tx.req;
            w <= 4'h3;
          end
        end
        2'h2: begin
          w <= w - 4'h1;
          if (w == 4'h0) begin
            eng_ev.tx_done <= !fail_en;
            eng_ev.tx_fail <= fail_en;
            st <= 2'h3;
          end
        end
        default: st <= 2'h0;
      endcase
    end
  end
endmodule

// ---- tb/can_mailbox_tx_control_test.sv ----
// register-level bench for the mailbox control block
// assumes a 6-bit counter so periodic sends repeat every 64 cycles
`timescale 1ns/10ps
module can_mailbox_tx_control_test;
  import cmt_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic fault = 1'b0;
  logic fail_en = 1'b0;
  logic rx_go = 1'b0;
  logic [3:0] rx_len = 4'h0;
  logic [3:0] eng_delay = 4'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic irq;
  cmt_tx_s eng_tx;
  cmt_ev_s eng_ev;
  logic [31:0] rd;
  int mismatches = 0;
  int checked = 0;

  always #4 hclk = ~hclk;

  cmt_mailbox_ctrl #(.CNT_W(6)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .eng_ev(eng_ev), .eng_tx(eng_tx), .transceiver_fault_in(fault), .irq(irq));
  cmt_engine_model u_eng (.hclk(hclk), .hresetn(hresetn), .eng_tx(eng_tx), .eng_ev(eng_ev),
    .fail_en(fail_en), .delay(eng_delay), .rx_go(rx_go), .rx_len(rx_len));

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // k=0 waits for a start, else for the end of an attempt
  task wait_ev(input int k);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (n < 500 && (k == 0 ? eng_ev.tx_start : (eng_ev.tx_done | eng_ev.tx_fail)) !== 1'b1);
    chk({31'h0, n < 500}, 32'h1);
  endtask

  task complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    complete_run;
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(CMT_OFS_CTRL, 32'h0);
    ahb(1'b1, CMT_OFS_CTRL, 32'hFFFF);
    rdc(CMT_OFS_CTRL, 32'h5FDF);
    ahb(1'b1, 8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h0);
    // plain send with embedded counter and a fault at frame end
    ahb(1'b1, CMT_OFS_DLO, 32'h33221100);
    ahb(1'b1, CMT_OFS_DHI, 32'h77665544);
    ahb(1'b1, CMT_OFS_MASK, 32'hF);
    ahb(1'b1, CMT_OFS_CTRL, 32'h0048);
    fault <= 1'b1;
    ahb(1'b1, CMT_OFS_PEND, 32'h1);
    wait_ev(0);
    chk({28'h0, eng_tx.dlc}, 32'h8);
    chk(eng_tx.data[31:0], 32'h33221100);
    wait_ev(1);
    repeat (2) @(posedge hclk);
    rdc(CMT_OFS_CTRL, 32'h0068);
    rdc(CMT_OFS_STAT, 32'h9);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b1, CMT_OFS_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    ahb(1'b1, CMT_OFS_STAT, 32'hF);
    ahb(1'b1, CMT_OFS_MASK, 32'hF);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    // single attempt that fails
    fault <= 1'b0;
    fail_en <= 1'b1;
    ahb(1'b1, CMT_OFS_CTRL, 32'h0801);
    ahb(1'b1, CMT_OFS_PEND, 32'h1);
    wait_ev(0);
    rdc(CMT_OFS_PEND, 32'h3);
    wait_ev(1);
    repeat (2) @(posedge hclk);
    ahb(1'b0, CMT_OFS_PEND, 32'h0);
    chk(rd & 32'h1, 32'h0);
    rdc(CMT_OFS_STAT, 32'h4);
    rdc(CMT_OFS_CTRL, 32'h0801);
    ahb(1'b1, CMT_OFS_STAT, 32'hF);
    // retried until it goes through, slow engine
    eng_delay <= 4'h5;
    ahb(1'b1, CMT_OFS_CTRL, 32'h0001);
    ahb(1'b1, CMT_OFS_PEND, 32'h1);
    wait_ev(0);
    wait_ev(0);
    fail_en <= 1'b0;
    wait_ev(1);
    eng_delay <= 4'h0;
    repeat (2) @(posedge hclk);
    ahb(1'b0, CMT_OFS_PEND, 32'h0);
    chk(rd & 32'h1, 32'h0);
    rdc(CMT_OFS_STAT, 32'h1);
    ahb(1'b1, CMT_OFS_STAT, 32'hF);
    // receive role never requests; cancel while idle
    ahb(1'b1, CMT_OFS_CTRL, 32'h0200);
    ahb(1'b1, CMT_OFS_PEND, 32'h1);
    repeat (10) @(posedge hclk);
    chk({31'h0, eng_tx.req}, 32'h0);
    ahb(1'b1, CMT_OFS_PEND, 32'h2);
    ahb(1'b0, CMT_OFS_PEND, 32'h0);
    chk(rd & 32'h1, 32'h0);
    rdc(CMT_OFS_STAT, 32'h4);
    ahb(1'b1, CMT_OFS_STAT, 32'hF);
    // automatic reply to a remote frame
    ahb(1'b1, CMT_OFS_CTRL, 32'h1102);
    rx_len <= 4'h5;
    rx_go <= 1'b1;
    @(posedge hclk);
    rx_go <= 1'b0;
    wait_ev(0);
    chk({28'h0, eng_tx.dlc}, 32'h5);
    wait_ev(1);
    repeat (2) @(posedge hclk);
    rdc(CMT_OFS_STAT, 32'h3);
    ahb(1'b1, CMT_OFS_STAT, 32'hF);
    // timed periodic send, stopped by clearing the enable
    ahb(1'b1, CMT_OFS_TRIG, 32'd20);
    rdc(CMT_OFS_TRIG, 32'h14);
    ahb(1'b1, CMT_OFS_CTRL, 32'h4081);
    ahb(1'b1, CMT_OFS_PEND, 32'h1);
    wait_ev(1);
    wait_ev(1);
    ahb(1'b0, CMT_OFS_PEND, 32'h0);
    chk(rd & 32'h1, 32'h1);
    wait_ev(0);
    ahb(1'b1, CMT_OFS_CTRL, 32'h0001);
    wait_ev(1);
    repeat (2) @(posedge hclk);
    ahb(1'b0, CMT_OFS_PEND, 32'h0);
    chk(rd & 32'h1, 32'h0);
    complete_run;
  end
endmodule
